// >>> src/lwb_defs.svh
`ifndef LWB_DEFS_SVH
`define LWB_DEFS_SVH
// ==========================================================
// Frame store, spreading and timing constants
`define LWB_FIFO_DEPTH 8'h80
`define LWB_SEQ0 32'h744A_C39B
`define LWB_ODD_MASK 32'hAAAA_AAAA
`define LWB_SYNC_THR 6'h1C
`define LWB_SFD_LO 4'h7
`define LWB_SFD_HI 4'hA
`define LWB_PRE_SYMS 4'h8
`define LWB_CRC_POLY 16'h8408
`define LWB_CCA_THR 8'h20
`define LWB_AGC_HI 8'h60
`define LWB_AGC_LO 8'h10
`define LWB_CLK_NS 100
`define LWB_CHIP_NS 500
`define LWB_CHIP_CYC ((`LWB_CHIP_NS + `LWB_CLK_NS - 1) / `LWB_CLK_NS)
`endif

// >>> src/lwb_pkg.sv
`default_nettype none
// ==========================================================
// Shared types
package lwb_pkg;
    typedef struct packed {
        logic valid;
        logic [7:0] i;
        logic [7:0] q;
    } lwb_iq_t;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] wdata;
        logic tx_start;
        logic ovf_clr;
    } lwb_port_req_t;
    typedef struct packed {
        logic [7:0] rdata;
        logic [7:0] rx_cnt;
        logic [7:0] tx_cnt;
        logic rx_ovf;
        logic crc_ok;
        logic tx_busy;
    } lwb_port_rsp_t;
    typedef struct packed {
        logic strobe;
        logic i_chip;
        logic q_chip;
    } lwb_dac_t;
    typedef enum logic [5:0] {
        LWB_RX_HUNT = 6'h01, LWB_RX_PRE = 6'h02, LWB_RX_SFD = 6'h04,
        LWB_RX_LEN = 6'h08, LWB_RX_DATA = 6'h10, LWB_RX_APP = 6'h20
    } lwb_rx_st_t;
    typedef enum logic [2:0] {
        LWB_TX_IDLE = 3'h1, LWB_TX_PRE = 3'h2, LWB_TX_DATA = 3'h4
    } lwb_tx_st_t;
endpackage : lwb_pkg
`default_nettype wire

// >>> src/lwb_baseband.sv
`include "lwb_defs.svh"
`default_nettype none
module lwb_baseband
    import lwb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic rx_en,
    input wire lwb_iq_t adc_iq,
    input wire lwb_port_req_t special_function_register_port_req,
    output lwb_port_rsp_t special_function_register_port_rsp,
    output lwb_dac_t dac_out,
    output logic sfd_irq,
    output logic cca_irq,
    output logic cca_clear
);
    // ==========================================================
    // Helpers
    function automatic logic [31:0] lwb_seq(input logic [3:0] s);
        logic [63:0] d;
        logic [31:0] r;
        d = {`LWB_SEQ0, `LWB_SEQ0} << {s[2:0], 2'b00};
        r = d[63:32];
        return s[3] ? (r ^ `LWB_ODD_MASK) : r;
    endfunction : lwb_seq
    function automatic logic [5:0] lwb_corr(input logic [31:0] w, input logic [3:0] s);
        logic [31:0] m;
        logic [5:0] n;
        m = ~(w ^ lwb_seq(s));
        n = 6'h00;
        for (int k = 0; k < 32; k++) n = n + {5'h00, m[k]};
        return n;
    endfunction : lwb_corr
    function automatic logic [8:0] lwb_abs(input logic [8:0] v);
        return v[8] ? 9'(-v) : v;
    endfunction : lwb_abs

    // ==========================================================
    // Receive front end: filter, gain, energy, chip slicing
    logic [7:0] prev_i_r, prev_q_r, level, cor_best, rdata_r;
    logic [8:0] fi, fq;
    logic [9:0] mag;
    logic [11:0] scaled;
    logic [1:0] gain_r;
    logic phase_r, chip, tick, sym_done, byte_done, half_r, drop_r, ovf_r, crc_ok_r;
    logic [31:0] win_r, win_nxt;
    logic [3:0] best_sym, lo_r;
    logic [5:0] best_cor;
    logic [4:0] chip_cnt_r;
    always_comb
    begin
        fi = 9'({adc_iq.i[7], adc_iq.i}) + 9'({prev_i_r[7], prev_i_r});
        fq = 9'({adc_iq.q[7], adc_iq.q}) + 9'({prev_q_r[7], prev_q_r});
        mag = {1'b0, lwb_abs(fi)} + {1'b0, lwb_abs(fq)};
        scaled = {2'b00, mag} << gain_r;
        level = (|scaled[11:10]) ? 8'hFF : scaled[9:2];
        tick = adc_iq.valid & rx_en;
        chip = phase_r ? ~fq[8] : ~fi[8];
        win_nxt = {chip, win_r[31:1]};
    end
    // Sample history and chip phase
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            prev_i_r <= 8'h00;
            prev_q_r <= 8'h00;
            phase_r <= 1'b0;
            win_r <= 32'h0000_0000;
        end
        else if (tick)
        begin
            prev_i_r <= adc_iq.i;
            prev_q_r <= adc_iq.q;
            phase_r <= ~phase_r;
            win_r <= win_nxt;
        end
    end
    // Automatic gain control
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            gain_r <= 2'h0;
        else if (tick && level > `LWB_AGC_HI && gain_r != 2'h0)
            gain_r <= gain_r - 2'h1;
        else if (tick && level < `LWB_AGC_LO && gain_r != 2'h3)
            gain_r <= gain_r + 2'h1;
    end
    // Channel clear assessment and its event
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cca_clear <= 1'b0;
            cca_irq <= 1'b0;
        end
        else
        begin
            cca_irq <= 1'b0;
            if (tick && ((level < `LWB_CCA_THR) != cca_clear))
            begin
                cca_clear <= level < `LWB_CCA_THR;
                cca_irq <= 1'b1;
            end
        end
    end
    // Despreading against all sixteen sequences
    always_comb
    begin
        best_sym = 4'h0;
        best_cor = lwb_corr(win_nxt, 4'h0);
        for (int s = 1; s < 16; s++)
            if (lwb_corr(win_nxt, 4'(s)) > best_cor)
            begin
                best_cor = lwb_corr(win_nxt, 4'(s));
                best_sym = 4'(s);
            end
    end

    // ==========================================================
    // Receive frame sequencer
    lwb_rx_st_t rx_st_r;
    logic [6:0] rem_r;
    logic [7:0] rx_byte, peak_r, fifo_wdata;
    logic [15:0] crc_r;
    logic app_sel_r, fifo_we;
    assign sym_done = tick && chip_cnt_r == 5'h1F && rx_st_r != LWB_RX_HUNT;
    assign byte_done = sym_done && half_r && (rx_st_r == LWB_RX_LEN || rx_st_r == LWB_RX_DATA);
    assign rx_byte = {best_sym, lo_r};
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_st_r <= LWB_RX_HUNT;
            chip_cnt_r <= 5'h00;
            half_r <= 1'b0;
            lo_r <= 4'h0;
            rem_r <= 7'h00;
            app_sel_r <= 1'b0;
            sfd_irq <= 1'b0;
        end
        else
        begin
            sfd_irq <= 1'b0;
            if (tick)
                chip_cnt_r <= chip_cnt_r + 5'h01;
            if (sym_done)
            begin
                half_r <= ~half_r;
                lo_r <= best_sym;
            end
            if (!rx_en)
                rx_st_r <= LWB_RX_HUNT;
            else
            case (rx_st_r)
                LWB_RX_HUNT:
                    if (tick && lwb_corr(win_nxt, 4'h0) >= `LWB_SYNC_THR)
                    begin
                        rx_st_r <= LWB_RX_PRE;
                        chip_cnt_r <= 5'h00;
                    end
                LWB_RX_PRE:
                    if (sym_done && best_sym == `LWB_SFD_LO)
                        rx_st_r <= LWB_RX_SFD;
                    else if (sym_done && best_sym != 4'h0)
                        rx_st_r <= LWB_RX_HUNT;
                LWB_RX_SFD:
                    if (sym_done)
                    begin
                        rx_st_r <= (best_sym == `LWB_SFD_HI) ? LWB_RX_LEN : LWB_RX_HUNT;
                        sfd_irq <= best_sym == `LWB_SFD_HI;
                        half_r <= 1'b0;
                    end
                LWB_RX_LEN:
                    if (byte_done)
                    begin
                        rem_r <= rx_byte[6:0];
                        rx_st_r <= (rx_byte[6:0] == 7'h00) ? LWB_RX_APP : LWB_RX_DATA;
                    end
                LWB_RX_DATA:
                    if (byte_done)
                    begin
                        rem_r <= rem_r - 7'h01;
                        if (rem_r == 7'h01)
                            rx_st_r <= LWB_RX_APP;
                    end
                LWB_RX_APP:
                begin
                    app_sel_r <= ~app_sel_r;
                    if (app_sel_r)
                        rx_st_r <= LWB_RX_HUNT;
                end
                default: rx_st_r <= LWB_RX_HUNT;
            endcase
        end
    end
    // Frame CRC, peak level and last correlation
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            crc_r <= 16'h0000;
            peak_r <= 8'h00;
            cor_best <= 8'h00;
            crc_ok_r <= 1'b0;
        end
        else
        begin
            if (sfd_irq)
            begin
                crc_r <= 16'h0000;
                peak_r <= 8'h00;
            end
            else if (byte_done && rx_st_r == LWB_RX_DATA)
            begin
                crc_r <= crc_byte(crc_r, rx_byte);
            end
            if (tick && rx_st_r != LWB_RX_HUNT && level > peak_r)
                peak_r <= level;
            if (sym_done)
                cor_best <= {2'b00, best_cor};
            if (rx_st_r == LWB_RX_APP && !app_sel_r)
                crc_ok_r <= crc_r == 16'h0000;
        end
    end
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c;
        for (int k = 0; k < 8; k++)
            x = (x >> 1) ^ ((x[0] ^ d[k]) ? `LWB_CRC_POLY : 16'h0000);
        return x;
    endfunction : crc_byte
    // Bytes offered to the receive FIFO
    always_comb
    begin
        fifo_we = byte_done || rx_st_r == LWB_RX_APP;
        if (rx_st_r == LWB_RX_APP)
            fifo_wdata = app_sel_r ? {(crc_r == 16'h0000), cor_best[6:0]} : peak_r;
        else
            fifo_wdata = rx_byte;
    end

    // ==========================================================
    // Receive and transmit FIFOs
    logic [7:0] rx_mem [0:127];
    logic [7:0] tx_mem [0:127];
    logic [6:0] rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
    logic [7:0] rx_cnt_r, tx_cnt_r;
    logic rx_push, rx_pop, tx_push, tx_pop;
    assign rx_push = fifo_we && !drop_r && rx_cnt_r != `LWB_FIFO_DEPTH;
    assign rx_pop = special_function_register_port_req.rd && rx_cnt_r != 8'h00;
    assign tx_push = special_function_register_port_req.wr && tx_cnt_r != `LWB_FIFO_DEPTH;
    always_ff @(posedge core_clk)
    begin
        if (rx_push)
            rx_mem[rx_wp_r] <= fifo_wdata;
        if (tx_push)
            tx_mem[tx_wp_r] <= special_function_register_port_req.wdata;
    end
    // Pointers, counts, read data and overflow
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_wp_r <= 7'h00;
            rx_rp_r <= 7'h00;
            tx_wp_r <= 7'h00;
            tx_rp_r <= 7'h00;
            rx_cnt_r <= 8'h00;
            tx_cnt_r <= 8'h00;
            rdata_r <= 8'h00;
            drop_r <= 1'b0;
            ovf_r <= 1'b0;
        end
        else
        begin
            rx_wp_r <= rx_wp_r + 7'(rx_push);
            rx_rp_r <= rx_rp_r + 7'(rx_pop);
            rx_cnt_r <= rx_cnt_r + 8'(rx_push) - 8'(rx_pop);
            tx_wp_r <= tx_wp_r + 7'(tx_push);
            tx_rp_r <= tx_rp_r + 7'(tx_pop);
            tx_cnt_r <= tx_cnt_r + 8'(tx_push) - 8'(tx_pop);
            if (rx_pop)
                rdata_r <= rx_mem[rx_rp_r];
            if (sfd_irq)
                drop_r <= 1'b0;
            else if (fifo_we && rx_cnt_r == `LWB_FIFO_DEPTH)
                drop_r <= 1'b1;
            if (fifo_we && !drop_r && rx_cnt_r == `LWB_FIFO_DEPTH)
                ovf_r <= 1'b1;
            else if (special_function_register_port_req.ovf_clr)
                ovf_r <= 1'b0;
        end
    end

    // ==========================================================
    // Transmitter: preamble, delimiter, spreading
    lwb_tx_st_t tx_st_r;
    logic [2:0] div_r;
    logic [4:0] tx_chip_r;
    logic [3:0] pre_idx_r, tx_sym;
    logic [31:0] tx_word;
    logic tx_half_r, chip_tick, sym_end;
    assign chip_tick = tx_st_r != LWB_TX_IDLE && div_r == 3'(`LWB_CHIP_CYC - 1);
    assign sym_end = chip_tick && tx_chip_r == 5'h1F;
    assign tx_pop = sym_end && tx_st_r == LWB_TX_DATA && tx_half_r;
    // Chip pattern of the symbol on air
    assign tx_word = lwb_seq(tx_sym);
    always_comb
    begin
        if (tx_st_r == LWB_TX_DATA)
            tx_sym = tx_half_r ? tx_mem[tx_rp_r][7:4] : tx_mem[tx_rp_r][3:0];
        else if (pre_idx_r < `LWB_PRE_SYMS)
            tx_sym = 4'h0;
        else
            tx_sym = (pre_idx_r == `LWB_PRE_SYMS) ? `LWB_SFD_LO : `LWB_SFD_HI;
    end
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_st_r <= LWB_TX_IDLE;
            div_r <= 3'h0;
            tx_chip_r <= 5'h00;
            pre_idx_r <= 4'h0;
            tx_half_r <= 1'b0;
            dac_out <= '0;
        end
        else
        begin
            dac_out.strobe <= chip_tick;
            if (chip_tick)
            begin
                if (tx_chip_r[0])
                    dac_out.q_chip <= tx_word[tx_chip_r];
                else
                    dac_out.i_chip <= tx_word[tx_chip_r];
                tx_chip_r <= tx_chip_r + 5'h01;
            end
            div_r <= chip_tick || tx_st_r == LWB_TX_IDLE ? 3'h0 : div_r + 3'h1;
            case (tx_st_r)
                LWB_TX_IDLE:
                    if (special_function_register_port_req.tx_start && tx_cnt_r != 8'h00)
                    begin
                        tx_st_r <= LWB_TX_PRE;
                        pre_idx_r <= 4'h0;
                        tx_chip_r <= 5'h00;
                        tx_half_r <= 1'b0;
                    end
                LWB_TX_PRE:
                    if (sym_end)
                    begin
                        pre_idx_r <= pre_idx_r + 4'h1;
                        if (pre_idx_r == `LWB_PRE_SYMS + 4'h1)
                            tx_st_r <= LWB_TX_DATA;
                    end
                LWB_TX_DATA:
                    if (sym_end)
                    begin
                        tx_half_r <= ~tx_half_r;
                        if (tx_half_r && tx_cnt_r == 8'h01)
                            tx_st_r <= LWB_TX_IDLE;
                    end
                default: tx_st_r <= LWB_TX_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Port status
    assign special_function_register_port_rsp = '{rdata: rdata_r, rx_cnt: rx_cnt_r, tx_cnt: tx_cnt_r,
        rx_ovf: ovf_r, crc_ok: crc_ok_r, tx_busy: tx_st_r != LWB_TX_IDLE};
endmodule : lwb_baseband
`default_nettype wire

// >>> dv/lwb_loop_model.sv
`default_nettype none
// ==========================================================
// Radio loopback: each transmitted chip returns as one sample
module lwb_loop_model
    import lwb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire lwb_dac_t dac,
    input wire logic tx_busy,
    output var lwb_iq_t iq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic odd_r;
    // Chip to sample, silent rail zero, idle rails toggling
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            odd_r <= 1'b0;
            iq <= '0;
        end
        else
        begin
            iq.valid <= dac.strobe;
            if (dac.strobe)
            begin
                odd_r <= ~odd_r;
                iq.i <= odd_r ? 8'h00 : (dac.i_chip ? 8'h40 : 8'hC0);
                iq.q <= odd_r ? (dac.q_chip ? 8'h40 : 8'hC0) : 8'h00;
            end
            else
            begin
                iq.i <= ~iq.i;
                iq.q <= ~iq.q;
                if (!tx_busy)
                    odd_r <= 1'b0;
            end
        end
    end
endmodule : lwb_loop_model
`default_nettype wire

// >>> dv/lwb_baseband_sva.sv
`include "lwb_defs.svh"
`default_nettype none
// ==========================================================
// Port-level checks
module lwb_baseband_sva
    import lwb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic rx_en,
    input wire lwb_iq_t adc_iq,
    input wire lwb_port_req_t special_function_register_port_req,
    input wire lwb_port_rsp_t special_function_register_port_rsp,
    input wire lwb_dac_t dac_out,
    input wire logic sfd_irq,
    input wire logic cca_irq,
    input wire logic cca_clear
);
    timeunit 1ns;
    timeprecision 1ns;
    wire lwb_port_req_t rq = special_function_register_port_req;
    wire lwb_port_rsp_t rp = special_function_register_port_rsp;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_sfd_single: assert property (sfd_irq |=> !sfd_irq)
        else $error("delimiter pulse too long");
    chk_cca_cause: assert property (cca_irq |-> $changed(cca_clear) || $past(cca_clear) != $past(cca_clear, 2))
        else $error("channel pulse without change");
    chk_cca_mode: assert property (cca_irq |-> $past(rx_en))
        else $error("channel pulse outside receive mode");
    chk_busy_cause: assert property ($rose(rp.tx_busy) |-> $past(rq.tx_start))
        else $error("transmit began unasked");
    chk_first_chip: assert property ($rose(rp.tx_busy) |-> !dac_out.strobe [*5] ##1 dac_out.strobe)
        else $error("first chip late or early");
    chk_chip_space: assert property (dac_out.strobe |=> !dac_out.strobe [*4])
        else $error("chips closer than five cycles");
    chk_chip_hold: assert property (!dac_out.strobe |-> $stable(dac_out.i_chip) && $stable(dac_out.q_chip))
        else $error("chip moved between strobes");
    chk_tx_push: assert property (rq.wr && !rq.tx_start && !rp.tx_busy && rp.tx_cnt != 8'h80
        |=> rp.tx_cnt == $past(rp.tx_cnt) + 8'h01)
        else $error("transmit count missed a push");
    chk_fifo_bound: assert property (rp.tx_cnt <= `LWB_FIFO_DEPTH && rp.rx_cnt <= `LWB_FIFO_DEPTH)
        else $error("store count beyond depth");
    chk_ovf_sticky: assert property (rp.rx_ovf && !rq.ovf_clr |=> rp.rx_ovf)
        else $error("overflow flag dropped");
    cov_sfd: cover property (sfd_irq);
    cov_ovf: cover property ($rose(rp.rx_ovf));
    cov_tx: cover property ($rose(rp.tx_busy));
    cov_cca: cover property (cca_irq);
endmodule : lwb_baseband_sva
`default_nettype wire

// >>> dv/lwb_tb.sv
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; $display("ERROR %0t %h %h", $time, a, b); end end
// ==========================================================
// Loopback testbench
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import lwb_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b0;
    logic rx_en = 1'b0;
    lwb_iq_t iq;
    lwb_port_req_t req = '0;
    lwb_port_rsp_t rsp;
    lwb_dac_t dac;
    logic sfd_irq;
    logic cca_irq;
    logic cca_clear;
    logic exp_c;
    logic chip_q[$];
    logic [7:0] fr[$];
    logic [7:0] rq[$];
    int err_total = 0;
    int checked = 0;
    int seed = 11673;
    int sfd_n = 0;
    int chip_n = 0;
    int s0;
    int c0;
    int cca_n = 0;
    always #50 core_clk = ~core_clk;
    lwb_baseband dut_u (.core_clk(core_clk), .rst(rst), .rx_en(rx_en), .adc_iq(iq),
        .special_function_register_port_req(req), .special_function_register_port_rsp(rsp),
        .dac_out(dac), .sfd_irq(sfd_irq), .cca_irq(cca_irq), .cca_clear(cca_clear));
    lwb_loop_model loop_u (.core_clk(core_clk), .rst(rst), .dac(dac), .tx_busy(rsp.tx_busy), .iq(iq));
    // Chip stream against expectation, delimiter count
    always @(posedge core_clk)
    begin
        if (sfd_irq)
            sfd_n++;
        if (cca_irq)
            cca_n++;
        if (dac.strobe)
        begin
            exp_c = chip_q.size() ? chip_q.pop_front() : 1'bx;
            `CHK(chip_n[0] ? dac.q_chip : dac.i_chip, exp_c)
            chip_n++;
        end
    end
    function automatic logic [31:0] spread(input logic [3:0] s);
        logic [63:0] t;
        t = {32'h744A_C39B, 32'h744A_C39B} << (4 * s[2:0]);
        return t[63:32] ^ (s[3] ? 32'hAAAA_AAAA : 32'h0000_0000);
    endfunction : spread
    function automatic logic [15:0] crc16(input int n);
        logic [15:0] c;
        c = 16'h0000;
        for (int k = 1; k <= n; k++)
        begin
            c = c ^ {8'h00, fr[k]};
            for (int j = 0; j < 8; j++)
                c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
        end
        return c;
    endfunction : crc16
    task automatic end_sim();
        if (err_total == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic add_sym(input logic [3:0] s);
        logic [31:0] w;
        w = spread(s);
        for (int j = 0; j < 32; j++)
            chip_q.push_back(w[j]);
    endtask : add_sym
    // Load a frame, start it, wait until sent and stored
    task automatic send(input int n, input logic bad);
        logic [15:0] c;
        int k;
        fr = {};
        fr.push_back(8'(n + 2));
        for (k = 0; k < n; k++)
            fr.push_back(8'($random(seed)));
        c = crc16(n) ^ {15'h0000, bad};
        fr.push_back(c[7:0]);
        fr.push_back(c[15:8]);
        chip_q = {};
        chip_n = 0;
        for (k = 0; k < 10; k++)
            add_sym(k < 8 ? 4'h0 : (k == 8 ? 4'h7 : 4'hA));
        foreach (fr[i])
        begin
            add_sym(fr[i][3:0]);
            add_sym(fr[i][7:4]);
            req.wr <= 1'b1;
            req.wdata <= fr[i];
            @(posedge core_clk);
        end
        if (fr.size() == 128)
            @(posedge core_clk);
        req.wr <= 1'b0;
        @(posedge core_clk);
        `CHK(rsp.tx_cnt, 8'(fr.size()))
        req.tx_start <= 1'b1;
        @(posedge core_clk);
        req.tx_start <= 1'b0;
        repeat (2) @(posedge core_clk);
        for (k = 0; k < 50000 && rsp.tx_busy !== 1'b0; k++)
            @(posedge core_clk);
        if (k == 50000)
        begin
            err_total++;
            end_sim();
        end
        repeat (20) @(posedge core_clk);
        `CHK(chip_q.size(), 0)
    endtask : send
    task automatic drain(input int n);
        rq = {};
        req.rd <= 1'b1;
        for (int k = 0; k < n; k++)
        begin
            @(posedge core_clk);
            if (k == n - 1)
                req.rd <= 1'b0;
            if (k > 0)
                rq.push_back(rsp.rdata);
        end
        @(posedge core_clk);
        rq.push_back(rsp.rdata);
    endtask : drain
    // ==========================================================
    // Main sequence
    initial
    begin
        rst <= 1'b1;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        rx_en <= 1'b1;
        @(posedge core_clk);
        for (int t = 0; t < 4; t++)
        begin
            s0 = sfd_n;
            send(t == 0 ? 0 : 1 + ($random(seed) & 7), t == 3);
            `CHK(sfd_n, s0 + 1)
            `CHK(rsp.rx_cnt, 8'(fr.size() + 2))
            `CHK(rsp.crc_ok, t != 3)
            drain(fr.size() + 2);
            foreach (fr[k])
                `CHK(rq[k], fr[k])
            `CHK(rq[fr.size() + 1][7], t != 3)
            `CHK(rsp.rx_cnt, 8'h00)
        end
        rx_en <= 1'b0;
        s0 = sfd_n;
        c0 = cca_n;
        send(3, 1'b0);
        `CHK(sfd_n, s0)
        `CHK(cca_n, c0)
        `CHK(rsp.rx_cnt, 8'h00)
        rx_en <= 1'b1;
        send(125, 1'b0);
        `CHK(rsp.rx_ovf, 1'b1)
        `CHK(rsp.rx_cnt, 8'h80)
        drain(128);
        foreach (rq[k])
            `CHK(rq[k], fr[k])
        req.ovf_clr <= 1'b1;
        @(posedge core_clk);
        req.ovf_clr <= 1'b0;
        @(posedge core_clk);
        `CHK(rsp.rx_ovf, 1'b0)
        end_sim();
    end
endmodule : testbench
bind lwb_baseband lwb_baseband_sva chk_u (.core_clk(core_clk), .rst(rst), .rx_en(rx_en), .adc_iq(adc_iq),
    .special_function_register_port_req(special_function_register_port_req),
    .special_function_register_port_rsp(special_function_register_port_rsp),
    .dac_out(dac_out), .sfd_irq(sfd_irq), .cca_irq(cca_irq), .cca_clear(cca_clear));
`default_nettype wire
